// [src/secure_frame_tx_encrypt_defines.vh]
// constants for the transmit security control block
// assumes 10-bit register addresses, short space zero-extended
`ifndef SECURE_FRAME_TX_ENCRYPT_DEFINES_VH
`define SECURE_FRAME_TX_ENCRYPT_DEFINES_VH
`define ADDR_BEACON_CTRL 10'h01A
`define ADDR_NORMAL_CTRL 10'h01B
`define ADDR_SLOT1_CTRL 10'h01C
`define ADDR_SLOT2_CTRL 10'h01D
`define ADDR_TX_RESULT 10'h024
`define ADDR_CIPHER_A 10'h02C
`define ADDR_CIPHER_B 10'h02D
`define ADDR_INT_FLAGS 10'h031
`define ADDR_INT_ENABLES 10'h032
`define ADDR_CIPHER_C 10'h037
`define KEY_SPACE_TOP 4'hA
`define KEY_SLOT_NORMAL 2'h0
`define KEY_SLOT_SLOT1 2'h1
`define KEY_SLOT_SHARED 2'h2
`define KEY_SLOT_RX 2'h3
`define CTRL_TRIG 0
`define CTRL_SEC 1
`define RETRY_MSB 7
`define RETRY_LSB 6
`define RES_NORMAL_FAIL 0
`define RES_SLOT1_OK 1
`define RES_SLOT2_OK 2
`define RES_SLOT1_NO_TIME 3
`define RES_SLOT2_NO_TIME 4
`define RES_CHANNEL_BUSY 5
`define FLAG_NORMAL_DONE 0
`define FLAG_SLOT1_DONE 1
`define FLAG_SLOT2_DONE 2
`define FIFO_NORMAL 2'h0
`define FIFO_SLOT1 2'h1
`define FIFO_SLOT2 2'h2
`define FIFO_BEACON 2'h3
`define SUITE_NONE 3'h0
`define SUITE_CTR 3'h1
`define SUITE_CCM_128 3'h2
`define SUITE_CCM_64 3'h3
`define SUITE_CCM_32 3'h4
`define SUITE_CBC_128 3'h5
`define SUITE_CBC_64 3'h6
`define SUITE_CBC_32 3'h7
`define MIC_128 5'h10
`define MIC_64 5'h08
`define MIC_32 5'h04
`define SPI_SHORT_HDR 5'h08
`define SPI_LONG_HDR 5'h0C
`define RST_BYTE 8'h00
`endif

// [src/secure_frame_tx_encrypt.v]
// transmit security control: register port, key memory, fifo arbiter
// assumes an external AES-128 engine and radio that report completion
`timescale 1ns/1ns
`include "secure_frame_tx_encrypt_defines.vh"
`default_nettype none
module secure_frame_tx_encrypt (
  input wire clk_in,
  input wire resetn_in,
  input wire spi_sck_in,
  input wire spi_cs_n_in,
  input wire spi_sdi_in,
  output reg spi_sdo_out,
  output reg tx_start_out,
  output reg [1:0] tx_fifo_sel_out,
  output reg tx_secure_out,
  output reg [2:0] tx_suite_out,
  output reg tx_encrypt_out,
  output reg tx_auth_out,
  output reg [4:0] tx_mic_bytes_out,
  output reg [127:0] tx_key_out,
  input wire tx_done_in,
  input wire tx_fail_in,
  input wire [1:0] tx_retries_in,
  input wire tx_busy_fail_in,
  input wire tx_no_time_in
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  reg [7:0] key_mem [0:63];
  reg [1:0] beacon_fifo_ctrl_reg;
  reg [4:0] normal_fifo_ctrl_reg;
  reg [7:0] slot1_fifo_ctrl_reg;
  reg [7:0] slot2_fifo_ctrl_reg;
  reg [7:0] tx_result_reg;
  reg [7:0] cipher_ctrl_a_reg;
  reg [7:0] cipher_ctrl_b_reg;
  reg [7:0] cipher_ctrl_c_reg;
  reg [7:0] interrupt_flags_reg;
  reg [7:0] interrupt_enables_reg;
  reg [1:0] state_reg;
  reg [1:0] cur_fifo_reg;
  reg [1:0] key_slot_reg;

  // serial port state
  reg sck_d_reg;
  reg [4:0] bit_cnt_reg;
  reg [4:0] hdr_len_reg;
  reg [11:0] shift_in_reg;
  reg [7:0] shift_out_reg;
  reg [9:0] addr_reg;
  reg write_reg;

  wire sck_rise = spi_sck_in & ~sck_d_reg;
  wire sck_fall = ~spi_sck_in & sck_d_reg;
  wire [11:0] shift_in_next = {shift_in_reg[10:0], spi_sdi_in};
  wire hdr_done = sck_rise && (bit_cnt_reg == hdr_len_reg - 5'h01);
  wire wr_fire = sck_rise && write_reg && (bit_cnt_reg == hdr_len_reg + 5'h07);
  wire rd_load = sck_fall && !write_reg && (bit_cnt_reg == hdr_len_reg);
  wire [7:0] wr_data = shift_in_next[7:0];
  wire key_hit = (addr_reg[9:6] == `KEY_SPACE_TOP);

  // register read mux
  reg [7:0] rd_data;
  always @* begin
    rd_data = `RST_BYTE;
    if (key_hit) begin
      rd_data = key_mem[addr_reg[5:0]];
    end else begin
      case (addr_reg)
        `ADDR_BEACON_CTRL: rd_data = {6'h00, beacon_fifo_ctrl_reg};
        `ADDR_NORMAL_CTRL: rd_data = {3'h0, normal_fifo_ctrl_reg};
        `ADDR_SLOT1_CTRL: rd_data = slot1_fifo_ctrl_reg;
        `ADDR_SLOT2_CTRL: rd_data = slot2_fifo_ctrl_reg;
        `ADDR_TX_RESULT: rd_data = tx_result_reg;
        `ADDR_CIPHER_A: rd_data = cipher_ctrl_a_reg;
        `ADDR_CIPHER_B: rd_data = cipher_ctrl_b_reg;
        `ADDR_INT_FLAGS: rd_data = interrupt_flags_reg;
        `ADDR_INT_ENABLES: rd_data = interrupt_enables_reg;
        `ADDR_CIPHER_C: rd_data = cipher_ctrl_c_reg;
        default: rd_data = `RST_BYTE;
      endcase
    end
  end

  // serial slave: short header 0,a5..a0,w; long header 1,a9..a0,w
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      sck_d_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      hdr_len_reg <= `SPI_SHORT_HDR;
      shift_in_reg <= 12'h000;
      shift_out_reg <= `RST_BYTE;
      addr_reg <= 10'h000;
      write_reg <= 1'b0;
      spi_sdo_out <= 1'b0;
    end else begin
      sck_d_reg <= spi_sck_in;
      if (spi_cs_n_in) begin
        // deselected: serial out rests low, no stale read bits left
        bit_cnt_reg <= 5'h00;
        write_reg <= 1'b0;
        shift_out_reg <= `RST_BYTE;
        spi_sdo_out <= 1'b0;
      end else if (sck_rise) begin
        shift_in_reg <= shift_in_next;
        if (bit_cnt_reg != 5'h1F) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        if (bit_cnt_reg == 5'h00) begin
          hdr_len_reg <= spi_sdi_in ? `SPI_LONG_HDR : `SPI_SHORT_HDR;
        end
        if (hdr_done) begin
          write_reg <= shift_in_next[0];
          if (hdr_len_reg == `SPI_LONG_HDR) begin
            addr_reg <= shift_in_next[10:1];
          end else begin
            addr_reg <= {4'h0, shift_in_next[6:1]};
          end
        end
      end else if (sck_fall) begin
        if (rd_load) begin
          shift_out_reg <= {rd_data[6:0], 1'b0};
          spi_sdo_out <= rd_data[7];
        end else begin
          shift_out_reg <= {shift_out_reg[6:0], 1'b0};
          spi_sdo_out <= shift_out_reg[7];
        end
      end
    end
  end

  // key memory, no reset on the array itself
  always @(posedge clk_in) begin
    if (wr_fire && key_hit) begin
      key_mem[addr_reg[5:0]] <= wr_data;
    end
  end

  // pending requests; beacon first, then slotted, then normal
  wire beacon_req = beacon_fifo_ctrl_reg[`CTRL_TRIG];
  wire slot1_req = slot1_fifo_ctrl_reg[`CTRL_TRIG];
  wire slot2_req = slot2_fifo_ctrl_reg[`CTRL_TRIG];
  wire normal_req = normal_fifo_ctrl_reg[`CTRL_TRIG];
  wire any_req = beacon_req | slot1_req | slot2_req | normal_req;
  reg [1:0] pick_fifo;
  reg [1:0] pick_slot;
  reg pick_sec;
  reg [2:0] pick_suite;
  always @* begin
    pick_fifo = `FIFO_NORMAL;
    pick_slot = `KEY_SLOT_NORMAL;
    pick_sec = normal_fifo_ctrl_reg[`CTRL_SEC];
    pick_suite = cipher_ctrl_a_reg[2:0];
    if (beacon_req) begin
      pick_fifo = `FIFO_BEACON;
      pick_slot = `KEY_SLOT_SHARED;
      pick_sec = beacon_fifo_ctrl_reg[`CTRL_SEC];
      pick_suite = cipher_ctrl_b_reg[6:4];
    end else if (slot1_req) begin
      pick_fifo = `FIFO_SLOT1;
      pick_slot = `KEY_SLOT_SLOT1;
      pick_sec = slot1_fifo_ctrl_reg[`CTRL_SEC];
      pick_suite = cipher_ctrl_c_reg[2:0];
    end else if (slot2_req) begin
      pick_fifo = `FIFO_SLOT2;
      pick_slot = `KEY_SLOT_SHARED;
      pick_sec = slot2_fifo_ctrl_reg[`CTRL_SEC];
      pick_suite = cipher_ctrl_c_reg[5:3];
    end
  end

  // suite decode to engine controls
  reg dec_enc;
  reg dec_auth;
  reg [4:0] dec_mic;
  always @* begin
    dec_enc = 1'b0;
    dec_auth = 1'b0;
    dec_mic = 5'h00;
    case (pick_suite)
      `SUITE_CTR: dec_enc = 1'b1;
      `SUITE_CCM_128: begin dec_enc = 1'b1; dec_auth = 1'b1; dec_mic = `MIC_128; end
      `SUITE_CCM_64: begin dec_enc = 1'b1; dec_auth = 1'b1; dec_mic = `MIC_64; end
      `SUITE_CCM_32: begin dec_enc = 1'b1; dec_auth = 1'b1; dec_mic = `MIC_32; end
      `SUITE_CBC_128: begin dec_auth = 1'b1; dec_mic = `MIC_128; end
      `SUITE_CBC_64: begin dec_auth = 1'b1; dec_mic = `MIC_64; end
      `SUITE_CBC_32: begin dec_auth = 1'b1; dec_mic = `MIC_32; end
      default: dec_enc = 1'b0;
    endcase
  end

  // sequencer towards the cipher engine and radio
  wire done_now = (state_reg == ST_WAIT) && tx_done_in;
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      cur_fifo_reg <= `FIFO_NORMAL;
      key_slot_reg <= `KEY_SLOT_NORMAL;
      tx_start_out <= 1'b0;
      tx_fifo_sel_out <= `FIFO_NORMAL;
      tx_secure_out <= 1'b0;
      tx_suite_out <= `SUITE_NONE;
      tx_encrypt_out <= 1'b0;
      tx_auth_out <= 1'b0;
      tx_mic_bytes_out <= 5'h00;
    end else begin
      tx_start_out <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (any_req) begin
            state_reg <= ST_LOAD;
            cur_fifo_reg <= pick_fifo;
            key_slot_reg <= pick_slot;
            tx_fifo_sel_out <= pick_fifo;
            tx_secure_out <= pick_sec && (pick_suite != `SUITE_NONE);
            tx_suite_out <= pick_sec ? pick_suite : `SUITE_NONE;
            tx_encrypt_out <= pick_sec && dec_enc;
            tx_auth_out <= pick_sec && dec_auth;
            tx_mic_bytes_out <= pick_sec ? dec_mic : 5'h00;
          end
        end
        ST_LOAD: begin
          tx_start_out <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (tx_done_in) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // key copy into the engine key register, one byte per lane
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : key_lane
      localparam [3:0] LANE = g;
      always @(posedge clk_in) begin
        if (!resetn_in) begin
          tx_key_out[g*8 +: 8] <= `RST_BYTE;
        end else if (state_reg == ST_LOAD) begin
          tx_key_out[g*8 +: 8] <= key_mem[{key_slot_reg, LANE}];
        end
      end
    end
  endgenerate

  // control, status and flag registers; hardware set wins over host clear
  wire wr_reg = wr_fire && !key_hit;
  wire flags_read = rd_load && (addr_reg == `ADDR_INT_FLAGS);
  wire fail_busy = tx_fail_in && tx_busy_fail_in;
  wire fail_time = tx_fail_in && tx_no_time_in;
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      beacon_fifo_ctrl_reg <= 2'h0;
      normal_fifo_ctrl_reg <= 5'h00;
      slot1_fifo_ctrl_reg <= `RST_BYTE;
      slot2_fifo_ctrl_reg <= `RST_BYTE;
      tx_result_reg <= `RST_BYTE;
      cipher_ctrl_a_reg <= `RST_BYTE;
      cipher_ctrl_b_reg <= `RST_BYTE;
      cipher_ctrl_c_reg <= `RST_BYTE;
      interrupt_flags_reg <= `RST_BYTE;
      interrupt_enables_reg <= `RST_BYTE;
    end else begin
      if (flags_read) begin
        interrupt_flags_reg <= `RST_BYTE;
      end
      if (wr_reg) begin
        case (addr_reg)
          `ADDR_BEACON_CTRL: beacon_fifo_ctrl_reg <= wr_data[1:0];
          `ADDR_NORMAL_CTRL: normal_fifo_ctrl_reg <= wr_data[4:0];
          `ADDR_SLOT1_CTRL: slot1_fifo_ctrl_reg[5:0] <= wr_data[5:0];
          `ADDR_SLOT2_CTRL: slot2_fifo_ctrl_reg[5:0] <= wr_data[5:0];
          `ADDR_CIPHER_A: cipher_ctrl_a_reg <= wr_data;
          `ADDR_CIPHER_B: cipher_ctrl_b_reg <= {1'b0, wr_data[6:4], 2'h0, wr_data[1:0]};
          `ADDR_INT_ENABLES: interrupt_enables_reg <= wr_data;
          `ADDR_CIPHER_C: cipher_ctrl_c_reg <= wr_data;
          default: interrupt_enables_reg <= interrupt_enables_reg;
        endcase
      end
      if (done_now) begin
        case (cur_fifo_reg)
          `FIFO_NORMAL: begin
            normal_fifo_ctrl_reg[`CTRL_TRIG] <= 1'b0;
            tx_result_reg[`RES_NORMAL_FAIL] <= tx_fail_in;
            tx_result_reg[`RETRY_MSB:`RETRY_LSB] <= tx_retries_in;
            tx_result_reg[`RES_CHANNEL_BUSY] <= fail_busy;
            interrupt_flags_reg[`FLAG_NORMAL_DONE] <= 1'b1;
          end
          `FIFO_SLOT1: begin
            slot1_fifo_ctrl_reg[`CTRL_TRIG] <= 1'b0;
            slot1_fifo_ctrl_reg[`RETRY_MSB:`RETRY_LSB] <= tx_retries_in;
            tx_result_reg[`RES_SLOT1_OK] <= ~tx_fail_in;
            tx_result_reg[`RES_SLOT1_NO_TIME] <= fail_time;
            tx_result_reg[`RES_CHANNEL_BUSY] <= fail_busy;
            interrupt_flags_reg[`FLAG_SLOT1_DONE] <= 1'b1;
          end
          `FIFO_SLOT2: begin
            slot2_fifo_ctrl_reg[`CTRL_TRIG] <= 1'b0;
            slot2_fifo_ctrl_reg[`RETRY_MSB:`RETRY_LSB] <= tx_retries_in;
            tx_result_reg[`RES_SLOT2_OK] <= ~tx_fail_in;
            tx_result_reg[`RES_SLOT2_NO_TIME] <= fail_time;
            tx_result_reg[`RES_CHANNEL_BUSY] <= fail_busy;
            interrupt_flags_reg[`FLAG_SLOT2_DONE] <= 1'b1;
          end
          default: beacon_fifo_ctrl_reg[`CTRL_TRIG] <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [bench/secure_frame_tx_encrypt_sva.sv]
// port assertions for the transmit security block
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ns
`default_nettype none
module tx_sec_checker (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdo_out,
  input wire logic tx_start_out,
  input wire logic [1:0] tx_fifo_sel_out,
  input wire logic tx_secure_out,
  input wire logic [2:0] tx_suite_out,
  input wire logic tx_encrypt_out,
  input wire logic tx_auth_out,
  input wire logic [4:0] tx_mic_bytes_out,
  input wire logic tx_done_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_start_pulse: assert property (tx_start_out |=> !tx_start_out)
    else $error("start wider than one cycle");
  a_secure_code: assert property (tx_start_out |-> tx_secure_out == (tx_suite_out != 3'h0))
    else $error("secure flag disagrees with suite");
  a_encrypt_code: assert property (tx_start_out |->
    tx_encrypt_out == (tx_suite_out >= 3'h1 && tx_suite_out <= 3'h4))
    else $error("encrypt flag disagrees with suite");
  a_auth_code: assert property (tx_start_out |-> tx_auth_out == (tx_suite_out >= 3'h2))
    else $error("auth flag disagrees with suite");
  a_mic_size: assert property (tx_start_out |-> tx_mic_bytes_out ==
    ((tx_suite_out == 3'h2 || tx_suite_out == 3'h5) ? 5'h10 :
    (tx_suite_out == 3'h3 || tx_suite_out == 3'h6) ? 5'h08 :
    (tx_suite_out == 3'h4 || tx_suite_out == 3'h7) ? 5'h04 : 5'h00))
    else $error("mic size wrong");
  a_sel_settled: assert property (tx_start_out |-> $stable(tx_fifo_sel_out) && $stable(tx_suite_out))
    else $error("selection moved at start");
  a_sel_then_start: assert property ($changed(tx_fifo_sel_out) || $changed(tx_suite_out) |=> tx_start_out)
    else $error("no start after selection");
  a_sdo_quiet: assert property (spi_cs_n_in && $past(spi_cs_n_in) && $past(spi_cs_n_in, 2) |-> !spi_sdo_out)
    else $error("serial out busy while idle");
  c_beacon: cover property (tx_start_out && tx_fifo_sel_out == 2'h3);
  c_mac_only: cover property (tx_start_out && tx_auth_out && !tx_encrypt_out);
  c_done: cover property (tx_done_in);
endmodule
`default_nettype wire

// [bench/host_spi_model.sv]
// serial host model for the register port
// assumes mode 0, each bit clock four system cycles
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic sdi_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic xfer(input logic lng, input logic [9:0] a, input logic w,
                      input logic [7:0] wd, output logic [7:0] rd);
    logic [19:0] bits;
    int n;
    bits = lng ? {1'b1, a, w, wd} : {1'b0, a[5:0], w, wd, 4'h0};
    n = lng ? 20 : 16;
    rd = 8'h00;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_out = bits[19 - i];
      repeat (2) @(negedge clk_in);
      sck_out = 1'b1;
      if (i >= n - 8)
        rd = {rd[6:0], sdo_in};
      repeat (2) @(negedge clk_in);
      sck_out = 1'b0;
    end
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// [bench/secure_frame_tx_encrypt_bench.sv]
// self-checking bench for the transmit security block
// assumes the host model and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module secure_frame_tx_encrypt_bench;
  logic clk_in, resetn_in, sck, cs_n, sdi, sdo, start, secure, encrypt, auth;
  logic done, fail, busy, no_time;
  logic [1:0] sel, retries;
  logic [2:0] suite;
  logic [4:0] mic;
  logic [127:0] key;
  logic [7:0] rd, res_model;
  int n_fail, cmp_count;
  int n_start = 0;
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (start === 1'b1)
      n_start <= n_start + 1;
  end
  host_spi_model i_host (.clk_in(clk_in), .sdo_in(sdo), .sck_out(sck), .cs_n_out(cs_n),
    .sdi_out(sdi));
  secure_frame_tx_encrypt i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .spi_sck_in(sck),
    .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .tx_start_out(start),
    .tx_fifo_sel_out(sel), .tx_secure_out(secure), .tx_suite_out(suite),
    .tx_encrypt_out(encrypt), .tx_auth_out(auth), .tx_mic_bytes_out(mic), .tx_key_out(key),
    .tx_done_in(done), .tx_fail_in(fail), .tx_retries_in(retries), .tx_busy_fail_in(busy),
    .tx_no_time_in(no_time));
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    i_host.xfer(a > 10'h03F, a, 1'b1, d, rd);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
    i_host.xfer(a > 10'h03F, a, 1'b0, 8'h00, rd);
    chk($sformatf("reg %h", a), exp, rd);
  endtask
  function automatic logic [127:0] key_of(input logic [1:0] s);
    for (int i = 0; i < 16; i++)
      key_of[8*i +: 8] = {2'h0, s, i[3:0]};
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end
  initial begin
    logic [1:0] f;
    logic [2:0] s;
    {resetn_in, done, fail, retries, busy, no_time} = 7'h00;
    {n_fail, cmp_count, res_model} = 0;
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    rdc(10'h031, 8'h00);
    wr(10'h024, 8'hFF);
    rdc(10'h024, 8'h00);
    wr(10'h032, 8'hA5);
    rdc(10'h032, 8'hA5);
    wr(10'h02D, 8'hFF);
    rdc(10'h02D, 8'h73);
    for (int k = 0; k < 64; k++)
      wr(10'h280 + k, {2'h0, k[5:0]});
    rdc(10'h2B0, 8'h30);
    rdc(10'h2BF, 8'h3F);
    rdc(10'h2C0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      f = i[1:0];
      s = i[2:0];
      case (f)
        2'h0: wr(10'h02C, {5'h00, s});
        2'h1: wr(10'h037, {5'h00, s});
        2'h2: wr(10'h037, {2'h0, s, 3'h0});
        default: wr(10'h02D, {1'b0, s, 4'h0});
      endcase
      wr(f == 2'h3 ? 10'h01A : 10'h01B + f, 8'h03);
      // start pulse is counted one edge after the write task returns
      @(negedge clk_in);
      chk("starts", i + 1, n_start);
      chk("fifo", f, sel);
      chk("suite", s, suite);
      chk("secure", s != 3'h0, secure);
      chk("encrypt", s >= 3'h1 && s <= 3'h4, encrypt);
      chk("auth", s >= 3'h2, auth);
      chk("mic", s < 3'h2 ? 5'h00 : 5'h10 >> ((s - 3'h2) % 3'h3), mic);
      chk("key", key_of(f == 2'h3 ? 2'h2 : f), key);
      @(negedge clk_in);
      {done, fail, retries, busy, no_time} = {1'b1, i[0], i[2:1], 2'h3};
      @(negedge clk_in);
      {done, fail, retries, busy, no_time} = {1'b0, ~i[0], ~i[2:1], 2'h0};
      if (f == 2'h0)
        res_model = {i[2:1], i[0], res_model[4:1], i[0]};
      if (f == 2'h1)
        res_model[5:1] = {i[0], res_model[4], i[0], res_model[2], ~i[0]};
      if (f == 2'h2)
        res_model[5:1] = {i[0], i[0], res_model[3], ~i[0], res_model[1]};
      rdc(10'h024, res_model);
      rdc(10'h031, f == 2'h3 ? 8'h00 : 8'h01 << f);
      rdc(f == 2'h3 ? 10'h01A : 10'h01B + f, {(f == 2'h1 || f == 2'h2) ? i[2:1] : 2'h0, 6'h02});
    end
    end_of_test();
  end
endmodule
bind secure_frame_tx_encrypt tx_sec_checker i_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_sdo_out(spi_sdo_out), .tx_start_out(tx_start_out),
  .tx_fifo_sel_out(tx_fifo_sel_out), .tx_secure_out(tx_secure_out),
  .tx_suite_out(tx_suite_out), .tx_encrypt_out(tx_encrypt_out), .tx_auth_out(tx_auth_out),
  .tx_mic_bytes_out(tx_mic_bytes_out), .tx_done_in(tx_done_in));
`default_nettype wire
